// ==== hw/timer_blocks_pkg.sv ====
package timer_blocks_pkg;
  localparam int CNT_W = 4;
  localparam logic [3:0] MOD_MIN = 4'h5;
  localparam logic [3:0] MOD_MAX = 4'hf;
  localparam logic [3:0] QUINARY_TOP = 4'h4;
  localparam int TU_W = 7;
  localparam logic [6:0] TOTAL_UNITS = 7'h64;
  localparam logic [6:0] TAP_10 = 7'h0a;
  localparam logic [6:0] TAP_20 = 7'h14;
  localparam logic [6:0] TAP_50 = 7'h32;
  localparam logic [6:0] ZERO_UNITS = 7'h00;
  localparam logic [6:0] ONE_UNIT = 7'h01;
  localparam logic [3:0] ZERO_CNT = 4'h0;
  localparam logic [3:0] ONE_CNT = 4'h1;
  localparam logic [2:0] RING_A = 3'h1;
  localparam logic [2:0] RING_B = 3'h2;
  localparam logic [2:0] RING_C = 3'h4;

  typedef enum logic [1:0] {PERIOD_A, PERIOD_B, PERIOD_C} period_t;

  typedef struct packed {
    logic [TU_W-1:0] preset_a;
    logic [TU_W-1:0] preset_ab;
  } timer_cfg_t;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic carry_out;
  } counter_out_t;
endpackage

// ==== hw/modulo_counter.sv ====
`timescale 1ns/1ps
`default_nettype none
// Modulo-X counter stage: cascade by carry_out -> carry_in of next stage.
module modulo_counter (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic carry_in,
  input wire logic enable_in,
  input wire logic sync_clear,
  input wire logic [timer_blocks_pkg::CNT_W-1:0] modulus_in,
  output timer_blocks_pkg::counter_out_t cnt_out
);
  typedef struct packed {
    logic [timer_blocks_pkg::CNT_W-1:0] count;
  } mc_state_t;
  mc_state_t st_q;
  mc_state_t st_d;
  logic at_top;

  assign at_top = (st_q.count == modulus_in - timer_blocks_pkg::ONE_CNT);
  always_comb begin
    st_d = st_q;
    if (sync_clear) begin
      st_d.count = timer_blocks_pkg::ZERO_CNT;
    end else if (carry_in && enable_in) begin
      st_d.count = at_top ? timer_blocks_pkg::ZERO_CNT : st_q.count + timer_blocks_pkg::ONE_CNT;
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign cnt_out.count = st_q.count;
  assign cnt_out.carry_out = at_top && carry_in;

  AST_CO_HOLDS: assert property (@(posedge clk_in) disable iff (rst_in)
    (cnt_out.carry_out && !enable_in && !sync_clear) ##1 carry_in |-> cnt_out.carry_out)
    else $error("carry_out dropped without enabled edge");
  AST_NO_ADV: assert property (@(posedge clk_in) disable iff (rst_in)
    (!(carry_in && enable_in) && !sync_clear) |=> $stable(st_q.count))
    else $error("count moved without carry_in and enable");
  AST_CLEAR: assert property (@(posedge clk_in) disable iff (rst_in)
    sync_clear |=> st_q.count == timer_blocks_pkg::ZERO_CNT)
    else $error("sync_clear not taken on next edge");
endmodule // modulo_counter
`default_nettype wire

// ==== hw/modulo_counters_and_interval_timers.sv ====
`timescale 1ns/1ps
`default_nettype none
// Operation
// - carry_out high at max count with carry_in
// - count advances only with carry_in and enable
// - enable gates counting, not carry_out
// - carry_out lasts while max and carry_in
// - stages cascade carry_out into carry_in
// - moduli five to fifteen decode terminal count
// - edge pulse predicts flip-flop rising edge
// - inverted input gives falling edge pulse
// - enable high gives one-clock pulse
// - cycle counter counts each comparator rise
// - two-state: fixed total, preset first period
// - three-state timer period is 100 units
// - load state clears flip-flops and count
// - preset match enters B, asserts hold override
// - A+B decode sets second flip-flop, period C
// - after 100 units both clear, restart
// - sync clear acts next edge, ignoring enable
// - quinary counter clears one clock after carry
// - tap 10 moves ring to B
// - tap 50 arms, tap 20 sets at 60
// - next tap 20 at 80 moves ring to C
// - tap 100 returns ring to A
// - preset load is synchronous, ignores enable
module modulo_counters_and_interval_timers (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic run_in,
  input wire logic time_base_in,
  input wire logic chain_carry_in,
  input wire logic chain_enable_in,
  input wire logic [timer_blocks_pkg::CNT_W-1:0] modulus_in,
  input wire logic diff_in,
  input wire logic diff_invert_in,
  input wire logic diff_enable_in,
  input wire logic comparator_in,
  input wire logic preset_load_input,
  input wire logic [timer_blocks_pkg::CNT_W-1:0] preset_value_in,
  input wire timer_blocks_pkg::timer_cfg_t timer_cfg_in,
  output logic [2*timer_blocks_pkg::CNT_W-1:0] chain_count_out,
  output logic chain_carry_out,
  output logic edge_pulse_out,
  output logic [timer_blocks_pkg::CNT_W-1:0] cycle_count_out,
  output logic [timer_blocks_pkg::CNT_W-1:0] quinary_count_out,
  output logic two_state_b_out,
  output timer_blocks_pkg::period_t var_period_out,
  output logic integrator_hold_out,
  output logic [2:0] ring_out,
  output logic [timer_blocks_pkg::TU_W-1:0] preset_reg_out
);
  typedef struct packed {
    logic diff_ff;
    logic cmp_ff;
    logic [timer_blocks_pkg::CNT_W-1:0] cycle_cnt;
    logic [timer_blocks_pkg::TU_W-1:0] two_cnt;
    logic [timer_blocks_pkg::TU_W-1:0] variable_carry_counter;
    logic ff_first;
    logic ff_second;
    logic [timer_blocks_pkg::TU_W-1:0] multi_cnt;
    logic [2:0] ring;
    logic store_50;
    logic armed_60;
    logic [timer_blocks_pkg::CNT_W-1:0] preset_reg;
  } top_state_t;
  top_state_t st_q;
  top_state_t st_d;

  timer_blocks_pkg::counter_out_t stage_out [2];
  logic [1:0] stage_ci;
  logic diff_src;
  logic variable_carry_pulse;
  logic quin_co;
  logic var_hit_a;
  logic var_last;
  timer_blocks_pkg::counter_out_t quin_out;
  logic tap10, tap20, tap50, tap100;
  logic [timer_blocks_pkg::TU_W-1:0] multi_next;

  // Each stage after the first takes the previous stage's carry_out; the first takes chain_carry_in; one shared enable
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_stage
      if (gi == 0) begin : g_first
        assign stage_ci[gi] = chain_carry_in;
      end else begin : g_next
        assign stage_ci[gi] = stage_out[gi-1].carry_out;
      end
      modulo_counter u_stage (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .carry_in(stage_ci[gi]),
        .enable_in(chain_enable_in),
        .sync_clear(1'b0),
        .modulus_in(modulus_in),
        .cnt_out(stage_out[gi])
      );
    end
  endgenerate
  assign chain_count_out = {stage_out[1].count, stage_out[0].count};
  assign chain_carry_out = stage_out[1].carry_out;

  // Carry fed back to the clear input; the stage never reaches its own wrap
  modulo_counter u_quinary (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .carry_in(time_base_in),
    .enable_in(1'b1),
    .sync_clear(quin_co),
    .modulus_in(timer_blocks_pkg::MOD_MAX),
    .cnt_out(quin_out)
  );

  function automatic logic tap_hit(input logic [timer_blocks_pkg::TU_W-1:0] cnt,
                                   input logic [timer_blocks_pkg::TU_W-1:0] step);
    tap_hit = (cnt % step) == timer_blocks_pkg::ZERO_UNITS;
  endfunction

  assign diff_src = diff_in ^ diff_invert_in;
  // Pulse predicts the flip-flop's next 0->1; widens while enable stays low
  assign edge_pulse_out = diff_src && !st_q.diff_ff;
  // Terminal count decoded by a gate outside the stage, so only time-base units can clear it
  assign quin_co = (quin_out.count == timer_blocks_pkg::QUINARY_TOP) && time_base_in;
  assign var_hit_a = st_q.variable_carry_counter == timer_cfg_in.preset_a;
  assign var_last = st_q.variable_carry_counter == timer_blocks_pkg::TOTAL_UNITS - timer_blocks_pkg::ONE_UNIT;
  assign variable_carry_pulse = run_in && time_base_in &&
                                (st_q.variable_carry_counter == timer_cfg_in.preset_ab);
  assign multi_next = st_q.multi_cnt + timer_blocks_pkg::ONE_UNIT;
  assign tap10 = run_in && time_base_in && tap_hit(multi_next, timer_blocks_pkg::TAP_10);
  assign tap20 = run_in && time_base_in && tap_hit(multi_next, timer_blocks_pkg::TAP_20);
  assign tap50 = run_in && time_base_in && tap_hit(multi_next, timer_blocks_pkg::TAP_50);
  assign tap100 = run_in && time_base_in && (multi_next == timer_blocks_pkg::TOTAL_UNITS);

  always_comb begin
    st_d = st_q;
    if (diff_enable_in) begin
      st_d.diff_ff = diff_src;
    end
    st_d.cmp_ff = comparator_in;
    if (comparator_in && !st_q.cmp_ff) begin
      st_d.cycle_cnt = st_q.cycle_cnt + timer_blocks_pkg::ONE_CNT;
    end
    if (preset_load_input) begin
      st_d.preset_reg = preset_value_in;
    end
    if (!run_in) begin
      st_d.two_cnt = timer_blocks_pkg::ZERO_UNITS;
      st_d.variable_carry_counter = timer_blocks_pkg::ZERO_UNITS;
      st_d.ff_first = 1'b0;
      st_d.ff_second = 1'b0;
      st_d.multi_cnt = timer_blocks_pkg::ZERO_UNITS;
      st_d.ring = timer_blocks_pkg::RING_A;
      st_d.store_50 = 1'b0;
      st_d.armed_60 = 1'b0;
    end else if (time_base_in) begin
      // Two-state timer: fixed total, first period from preset
      if (st_q.two_cnt == timer_cfg_in.preset_ab) begin
        st_d.two_cnt = timer_blocks_pkg::ZERO_UNITS;
      end else begin
        st_d.two_cnt = st_q.two_cnt + timer_blocks_pkg::ONE_UNIT;
      end
      if (var_last) begin
        st_d.variable_carry_counter = timer_blocks_pkg::ZERO_UNITS;
        st_d.ff_first = 1'b0;
        st_d.ff_second = 1'b0;
      end else begin
        st_d.variable_carry_counter = st_q.variable_carry_counter + timer_blocks_pkg::ONE_UNIT;
        if (var_hit_a) begin
          st_d.ff_first = 1'b1;
        end
        if (variable_carry_pulse && st_q.ff_first) begin
          st_d.ff_second = 1'b1;
        end
      end
      // Multi-tap timer feeding the ring counter
      if (tap100) begin
        st_d.multi_cnt = timer_blocks_pkg::ZERO_UNITS;
        st_d.ring = timer_blocks_pkg::RING_A;
        st_d.store_50 = 1'b0;
        st_d.armed_60 = 1'b0;
      end else begin
        st_d.multi_cnt = multi_next;
        if (tap10 && st_q.ring == timer_blocks_pkg::RING_A) begin
          st_d.ring = timer_blocks_pkg::RING_B;
        end
        if (tap50) begin
          st_d.store_50 = 1'b1;
        end
        if (tap20 && st_q.store_50 && !st_q.armed_60) begin
          st_d.armed_60 = 1'b1;
        end
        if (tap20 && st_q.armed_60) begin
          st_d.ring = timer_blocks_pkg::RING_C;
        end
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= '0;
      st_q.ring <= timer_blocks_pkg::RING_A;
    end else begin
      st_q <= st_d;
    end
  end

  assign cycle_count_out = st_q.cycle_cnt;
  assign quinary_count_out = quin_out.count;
  assign two_state_b_out = st_q.two_cnt >= timer_cfg_in.preset_a;
  assign integrator_hold_out = st_q.ff_first && !st_q.ff_second;
  assign var_period_out = st_q.ff_second ? timer_blocks_pkg::PERIOD_C :
                          (st_q.ff_first ? timer_blocks_pkg::PERIOD_B : timer_blocks_pkg::PERIOD_A);
  assign ring_out = st_q.ring;
  assign preset_reg_out = {{(timer_blocks_pkg::TU_W-timer_blocks_pkg::CNT_W){1'b0}}, st_q.preset_reg};

  sequence s_rise;
    comparator_in && !st_q.cmp_ff;
  endsequence
  AST_CYCLE_ONCE: assert property (@(posedge clk_in) disable iff (rst_in)
    s_rise |=> cycle_count_out == $past(cycle_count_out) + timer_blocks_pkg::ONE_CNT)
    else $error("cycle counter missed a rise");
  AST_CYCLE_HOLD: assert property (@(posedge clk_in) disable iff (rst_in)
    !(comparator_in && !st_q.cmp_ff) |=> $stable(cycle_count_out))
    else $error("cycle counter moved without a rise");
  AST_EDGE_ONE: assert property (@(posedge clk_in) disable iff (rst_in)
    (edge_pulse_out && diff_enable_in) |=> !edge_pulse_out)
    else $error("edge pulse longer than one clock");
  AST_QUIN_CLR: assert property (@(posedge clk_in) disable iff (rst_in)
    quin_co |=> quinary_count_out == timer_blocks_pkg::ZERO_CNT)
    else $error("quinary counter did not recycle");
  AST_LOAD: assert property (@(posedge clk_in) disable iff (rst_in)
    !run_in |=> (var_period_out == timer_blocks_pkg::PERIOD_A && ring_out == timer_blocks_pkg::RING_A))
    else $error("load state not cleared");
  AST_PRESET: assert property (@(posedge clk_in) disable iff (rst_in)
    preset_load_input |=> preset_reg_out[timer_blocks_pkg::CNT_W-1:0] == $past(preset_value_in))
    else $error("preset not loaded");
  AST_RING_C: assert property (@(posedge clk_in) disable iff (rst_in)
    (run_in && time_base_in && tap20 && st_q.armed_60 && !tap100) |=> ring_out == timer_blocks_pkg::RING_C)
    else $error("ring did not enter C");
  AST_RING_A: assert property (@(posedge clk_in) disable iff (rst_in)
    tap100 |=> ring_out == timer_blocks_pkg::RING_A)
    else $error("ring did not return to A");

  // Steps that the timer and differentiator checks share
  sequence s_unit;
    run_in && time_base_in;
  endsequence
  sequence s_last_unit;
    s_unit ##0 var_last;
  endsequence
  sequence s_lead_edge;
    (diff_enable_in && !diff_invert_in && !diff_in) ##1 (!diff_invert_in && diff_in);
  endsequence
  sequence s_trail_edge;
    (diff_enable_in && diff_invert_in && diff_in) ##1 (diff_invert_in && !diff_in);
  endsequence
  AST_LEAD: assert property (@(posedge clk_in) disable iff (rst_in)
    s_lead_edge |-> edge_pulse_out)
    else $error("no pulse on leading edge");
  AST_TRAIL: assert property (@(posedge clk_in) disable iff (rst_in)
    s_trail_edge |-> edge_pulse_out)
    else $error("no pulse on trailing edge");
  AST_CHAIN_CO: assert property (@(posedge clk_in) disable iff (rst_in)
    chain_carry_out == (chain_carry_in && chain_count_out == {2{modulus_in - timer_blocks_pkg::ONE_CNT}}))
    else $error("cascade carry wrong");
  AST_ENTER_B: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_unit ##0 (var_hit_a && !var_last && !st_q.ff_first)) |=>
      (var_period_out == timer_blocks_pkg::PERIOD_B && integrator_hold_out))
    else $error("second period not entered at preset");
  AST_ENTER_C: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_unit ##0 (variable_carry_pulse && st_q.ff_first && !var_last)) |=>
      (var_period_out == timer_blocks_pkg::PERIOD_C && !integrator_hold_out))
    else $error("third period not entered at patched sum");
  AST_RESTART: assert property (@(posedge clk_in) disable iff (rst_in)
    s_last_unit |=>
      (var_period_out == timer_blocks_pkg::PERIOD_A && st_q.variable_carry_counter == timer_blocks_pkg::ZERO_UNITS))
    else $error("timer did not restart after full cycle");
  AST_LOAD_ZERO: assert property (@(posedge clk_in) disable iff (rst_in)
    !run_in |=>
      (st_q.variable_carry_counter == timer_blocks_pkg::ZERO_UNITS && !st_q.ff_first && !st_q.ff_second))
    else $error("load state left a count or flip-flop set");
  AST_TWO_WRAP: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_unit ##0 (st_q.two_cnt == timer_cfg_in.preset_ab)) |=> st_q.two_cnt == timer_blocks_pkg::ZERO_UNITS)
    else $error("two-state timer did not wrap at fixed total");
  AST_RING_B: assert property (@(posedge clk_in) disable iff (rst_in)
    (tap10 && st_q.ring == timer_blocks_pkg::RING_A && !tap100) |=> ring_out == timer_blocks_pkg::RING_B)
    else $error("ring did not enter B");
  AST_STORE_50: assert property (@(posedge clk_in) disable iff (rst_in)
    (tap50 && !tap100) |=> st_q.store_50)
    else $error("tap fifty not stored");
  AST_ARM_60: assert property (@(posedge clk_in) disable iff (rst_in)
    (tap20 && st_q.store_50 && !tap100) |=> st_q.armed_60)
    else $error("second flip-flop not set at sixty");
  AST_PRESET_KEEP: assert property (@(posedge clk_in) disable iff (rst_in)
    !preset_load_input |=> $stable(preset_reg_out))
    else $error("preset changed without load");
  AST_QUIN_STEP: assert property (@(posedge clk_in) disable iff (rst_in)
    (time_base_in && !quin_co) |=> quinary_count_out == $past(quinary_count_out) + timer_blocks_pkg::ONE_CNT)
    else $error("quinary counter missed a unit");
  AST_QUIN_IDLE: assert property (@(posedge clk_in) disable iff (rst_in)
    !time_base_in |=> $stable(quinary_count_out))
    else $error("quinary counter moved without a unit");
endmodule // modulo_counters_and_interval_timers
`default_nettype wire

// ==== dv/signal_source.sv ====
`timescale 1ns/1ps
`default_nettype none
// Far side: the selected time-base pulse train and one comparator output
module signal_source (
  input wire logic clk_in,
  input wire logic pulse_en_in,
  output logic time_base_out,
  output logic comparator_out
);
  initial begin
    time_base_out = 1'b0;
    comparator_out = 1'b0;
  end
  // One unit every second cycle; stands low while idle so no stray unit slips in
  always @(negedge clk_in) begin
    time_base_out <= pulse_en_in ? ~time_base_out : 1'b0;
  end
  // Comparison held for len cycles; the count must not depend on the length
  task automatic compare_hit(input int len);
    @(negedge clk_in);
    comparator_out = 1'b1;
    repeat (len) @(negedge clk_in);
    comparator_out = 1'b0;
    repeat (2) @(negedge clk_in);
  endtask
endmodule // signal_source
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic run_in = 1'b0;
  logic pulse_en = 1'b0;
  logic chain_carry_in = 1'b0;
  logic chain_enable_in = 1'b0;
  logic [3:0] modulus_in = 4'h5;
  logic diff_in = 1'b0;
  logic diff_invert_in = 1'b0;
  logic diff_enable = 1'b1;
  logic preset_load_input = 1'b0;
  logic [3:0] preset_value_in = 4'h0;
  timer_blocks_pkg::timer_cfg_t timer_cfg_in = '{preset_a: 7'h14, preset_ab: 7'h3c};
  logic time_base_in, comparator_in, chain_carry_out, edge_pulse_out, two_state_b_out, integrator_hold_out;
  logic [7:0] chain_count_out;
  logic [3:0] cycle_count_out, quinary_count_out;
  timer_blocks_pkg::period_t var_period_out;
  logic [2:0] ring_out;
  logic [6:0] preset_reg_out;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  int units = 0;

  signal_source signal_source_i (.clk_in(clk_in), .pulse_en_in(pulse_en), .time_base_out(time_base_in),
    .comparator_out(comparator_in));
  modulo_counters_and_interval_timers modulo_counters_and_interval_timers_i (.clk_in(clk_in), .rst_in(rst_in),
    .run_in(run_in), .time_base_in(time_base_in), .chain_carry_in(chain_carry_in),
    .chain_enable_in(chain_enable_in), .modulus_in(modulus_in), .diff_in(diff_in),
    .diff_invert_in(diff_invert_in), .diff_enable_in(diff_enable), .comparator_in(comparator_in),
    .preset_load_input(preset_load_input), .preset_value_in(preset_value_in), .timer_cfg_in(timer_cfg_in),
    .chain_count_out(chain_count_out), .chain_carry_out(chain_carry_out), .edge_pulse_out(edge_pulse_out),
    .cycle_count_out(cycle_count_out), .quinary_count_out(quinary_count_out),
    .two_state_b_out(two_state_b_out), .var_period_out(var_period_out),
    .integrator_hold_out(integrator_hold_out), .ring_out(ring_out), .preset_reg_out(preset_reg_out));

  always #5 clk_in = ~clk_in;

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      $display("BAD %0t run did not finish", $time);
      give_verdict();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk({7'h00, got}, {7'h00, exp}, what);
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  task automatic reset_dut(input int n);
    rst_in = 1'b1;
    step(n);
    rst_in = 1'b0;
  endtask

  task automatic test_chain(input int m);
    logic [3:0] t;
    t = 4'(m - 1);
    reset_dut(2);
    modulus_in = 4'(m);
    chain_carry_in = 1'b1;
    chain_enable_in = 1'b1;
    step(m - 1);
    chk(chain_count_out, {4'h0, t}, "low digit at top");
    chk_bit(chain_carry_out, 1'b0, "no carry below top");
    step(m * m - m);
    chk(chain_count_out, {t, t}, "both digits at top");
    chk_bit(chain_carry_out, 1'b1, "carry at top");
    chain_enable_in = 1'b0;
    step(4);
    chk(chain_count_out, {t, t}, "held without enable");
    chk_bit(chain_carry_out, 1'b1, "carry kept without enable");
    chain_carry_in = 1'b0;
    chain_enable_in = 1'b1;
    #1 chk_bit(chain_carry_out, 1'b0, "carry follows carry in");
    step(3);
    chk(chain_count_out, {t, t}, "held without carry in");
    chain_carry_in = 1'b1;
    step(1);
    chk(chain_count_out, 8'h00, "wrap to zero");
    chk_bit(chain_carry_out, 1'b0, "carry drops after wrap");
  endtask

  task automatic test_edge(input logic inv);
    diff_invert_in = inv;
    diff_in = inv;
    step(3);
    chk_bit(edge_pulse_out, 1'b0, "idle edge output");
    diff_in = ~inv;
    #1 chk_bit(edge_pulse_out, 1'b1, "edge pulse");
    step(1);
    chk_bit(edge_pulse_out, 1'b0, "pulse lasts one clock");
    step(2);
    chk_bit(edge_pulse_out, 1'b0, "single pulse per edge");
    diff_in = inv;
    #1 chk_bit(edge_pulse_out, 1'b0, "no pulse on other edge");
    step(2);
    // With enable low the flip-flop cannot follow, so the pulse stretches
    diff_enable = 1'b0;
    diff_in = ~inv;
    step(2);
    chk_bit(edge_pulse_out, 1'b1, "pulse held while enable low");
    diff_enable = 1'b1;
    step(1);
    chk_bit(edge_pulse_out, 1'b0, "pulse ends on enabled edge");
    diff_in = inv;
    step(2);
  endtask

  task automatic test_cycles();
    reset_dut(2);
    signal_source_i.compare_hit(1);
    signal_source_i.compare_hit(3);
    signal_source_i.compare_hit(8);
    chk({4'h0, cycle_count_out}, 8'h03, "one count per rise");
  endtask

  task automatic test_preset();
    preset_value_in = 4'h9;
    preset_load_input = 1'b1;
    step(1);
    chk({1'b0, preset_reg_out}, 8'h09, "preset taken");
    preset_load_input = 1'b0;
    preset_value_in = 4'h6;
    step(2);
    chk({1'b0, preset_reg_out}, 8'h09, "preset held");
  endtask

  // n is the running total of time units since run started
  task automatic tick(input int n, input logic [1:0] per, input logic [2:0] ring, input logic two,
      input logic [3:0] quin);
    while (units < n) begin
      @(posedge clk_in);
      if (time_base_in === 1'b1) units++;
    end
    @(negedge clk_in);
    chk({6'h00, var_period_out}, {6'h00, per}, "three state period");
    chk_bit(integrator_hold_out, per == timer_blocks_pkg::PERIOD_B, "hold in period B");
    chk({5'h00, ring_out}, {5'h00, ring}, "ring state");
    chk_bit(two_state_b_out, two, "two state period");
    chk({4'h0, quinary_count_out}, {4'h0, quin}, "quinary count");
  endtask

  task automatic test_timers();
    reset_dut(2);
    units = 0;
    run_in = 1'b1;
    pulse_en = 1'b1;
    tick(17, timer_blocks_pkg::PERIOD_A, timer_blocks_pkg::RING_B, 1'b0, 4'h2);
    tick(43, timer_blocks_pkg::PERIOD_B, timer_blocks_pkg::RING_B, 1'b1, 4'h3);
    tick(72, timer_blocks_pkg::PERIOD_C, timer_blocks_pkg::RING_B, 1'b0, 4'h2);
    tick(88, timer_blocks_pkg::PERIOD_C, timer_blocks_pkg::RING_C, 1'b1, 4'h3);
    tick(106, timer_blocks_pkg::PERIOD_A, timer_blocks_pkg::RING_A, 1'b1, 4'h1);
    run_in = 1'b0;
    pulse_en = 1'b0;
    step(2);
    chk({6'h00, var_period_out}, {6'h00, timer_blocks_pkg::PERIOD_A}, "load state period");
    chk({5'h00, ring_out}, {5'h00, timer_blocks_pkg::RING_A}, "load state ring");
    chk_bit(two_state_b_out, 1'b0, "load state two state");
  endtask

  initial begin
    step(12);
    rst_in = 1'b0;
    chk({5'h00, ring_out}, {5'h00, timer_blocks_pkg::RING_A}, "ring after reset");
    chk({6'h00, var_period_out}, {6'h00, timer_blocks_pkg::PERIOD_A}, "period after reset");
    chk(chain_count_out, 8'h00, "chain after reset");
    test_chain(5);
    test_chain(9);
    test_chain(15);
    test_edge(1'b0);
    test_edge(1'b1);
    test_cycles();
    test_preset();
    test_timers();
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
